// ---- rtl/mio_port_block.sv ----
// Multiplexed pin block: seven ports, function select, data, pull-ups,
// open drain, misc control and eight filtered external interrupts.
// Assumes pads resolve out/oe outside; stop_mode comes from aclk logic.
`timescale 1ns/1ps
`include "mio_cfg.svh"
module mio_port_block #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [`MIO_NPINS-1:0] pad_in,
    output logic [`MIO_NPINS-1:0] pad_out,
    output logic [`MIO_NPINS-1:0] pad_oe,
    output logic [`MIO_NPINS-1:0] pad_pullup_en,
    output logic [`MIO_NPINS-1:0] port_pin_sync,
    input wire logic [`MIO_NPINS-1:0] alt1_out,
    input wire logic [`MIO_NPINS-1:0] alt1_oe,
    input wire logic [`MIO_NPINS-1:0] alt2_out,
    input wire logic [`MIO_NPINS-1:0] alt2_oe,
    input wire logic stop_mode,
    input wire logic [3:0] clock_sources,
    output logic clock_output_pin,
    output logic [1:0] data_bus_pullup_en,
    output logic [1:0] usb_pad_ctrl,
    output logic irq
);
    function automatic int port_base(input int p);
        case (p)
            0: port_base = `MIO_BASE_A;
            1: port_base = `MIO_BASE_B;
            2: port_base = `MIO_BASE_C;
            3: port_base = `MIO_BASE_D;
            4: port_base = `MIO_BASE_E;
            5: port_base = `MIO_BASE_F;
            default: port_base = `MIO_BASE_G;
        endcase
    endfunction

    function automatic int port_width(input int p);
        case (p)
            0: port_width = `MIO_WIDTH_A;
            1: port_width = `MIO_WIDTH_B;
            2: port_width = `MIO_WIDTH_C;
            3: port_width = `MIO_WIDTH_D;
            4: port_width = `MIO_WIDTH_E;
            5: port_width = `MIO_WIDTH_F;
            default: port_width = `MIO_WIDTH_G;
        endcase
    endfunction

    function automatic int pin_port(input int i);
        int p;
        p = 0;
        for (int q = 1; q < `MIO_NPORTS; q++) begin
            if (i >= port_base(q)) begin
                p = q;
            end
        end
        pin_port = p;
    endfunction

    function automatic logic is_od_pin(input int i);
        is_od_pin = (i == `MIO_OD_PIN0) || (i == `MIO_OD_PIN1) || (i == `MIO_OD_PIN2)
            || (i == `MIO_OD_PIN3) || (i == `MIO_OD_PIN4) || (i == `MIO_OD_PIN5);
    endfunction

    function automatic int od_index(input int i);
        case (i)
            `MIO_OD_PIN0: od_index = 0;
            `MIO_OD_PIN1: od_index = 1;
            `MIO_OD_PIN2: od_index = 2;
            `MIO_OD_PIN3: od_index = 3;
            `MIO_OD_PIN4: od_index = 4;
            default: od_index = 5;
        endcase
    endfunction

    function automatic logic [31:0] width_mask(input int w);
        logic [32:0] m;
        m = (33'h1 << w) - 33'h1;
        width_mask = m[31:0];
    endfunction

    // Port A: one select bit per pin
    function automatic logic [31:0] con_mask(input int p);
        con_mask = (p == 0) ? width_mask(port_width(0)) : width_mask(2 * port_width(p));
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = val[8*b +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic [31:0] port_slice(input logic [`MIO_NPINS-1:0] v, input int p);
        logic [`MIO_NPINS-1:0] s;
        s = v >> port_base(p);
        port_slice = s[31:0] & width_mask(port_width(p));
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        logic [1:0] kind;
        kind = a[3:2];
        if (a < `MIO_OFS_PORT_END) begin
            addr_mapped = (kind != 2'h3) && !(a[6:4] == 3'h0 && kind == `MIO_OFS_UP);
        end else begin
            addr_mapped = (a == `MIO_OFS_OD) || (a == `MIO_OFS_MISC) || (a == `MIO_OFS_TRIG)
                || (a == `MIO_OFS_STATUS) || (a == `MIO_OFS_ENABLE) || (a == `MIO_OFS_CLEAR);
        end
    endfunction

    logic [31:0] con [`MIO_NPORTS];
    logic [31:0] dat [`MIO_NPORTS];
    logic [31:0] up [`MIO_NPORTS];
    logic [5:0] od_en;
    logic [31:0] misc;
    logic [3*`MIO_EXT_IRQ_INPUT_N-1:0] trig_cfg;
    logic [`MIO_EXT_IRQ_INPUT_N-1:0] irq_status;
    logic [`MIO_EXT_IRQ_INPUT_N-1:0] irq_enable;
    logic [`MIO_NPINS-1:0] sync1;
    logic [`MIO_NPINS-1:0] sync2;
    logic [`MIO_NPINS-1:0] hold_out;
    logic [`MIO_NPINS-1:0] hold_oe;
    logic [`MIO_NPINS-1:0] live_out;
    logic [`MIO_NPINS-1:0] live_oe;
    logic [`MIO_NPINS-1:0] rd_pins;
    logic [`MIO_EXT_IRQ_INPUT_N-1:0] ext_irq_input_filt;
    logic [`MIO_EXT_IRQ_INPUT_N-1:0] ext_irq_input_prev;
    logic [`MIO_EXT_IRQ_INPUT_N-1:0] ext_irq_input_mode;
    logic [`MIO_EXT_IRQ_INPUT_N-1:0] ext_irq_input_event;

    // AXI4-Lite slave state
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] rd_kind;
    logic [2:0] rd_port;
    logic [31:0] rd_word;
    logic [31:0] next_rdata;

    // Write commits once both halves are held
    wire do_write = aw_held && w_held && !bvalid;
    wire [2:0] wr_port = aw_addr_q[6:4];
    wire [1:0] wr_kind = aw_addr_q[3:2];
    wire wr_in_ports = aw_addr_q < `MIO_OFS_PORT_END;
    wire [31:0] clear_word = (do_write && aw_addr_q == `MIO_OFS_CLEAR)
        ? merge(32'h0000_0000, w_data_q, w_strb_q) : 32'h0000_0000;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `MIO_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= addr_mapped(aw_addr_q) ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Select resets give default functions
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int p = 0; p < `MIO_NPORTS; p++) begin
                con[p] <= (p == 0) ? `MIO_RST_CON_A :
                          (p == 1) ? `MIO_RST_CON_B : `MIO_RST_CON;
                dat[p] <= `MIO_RST_DAT;
                up[p] <= `MIO_RST_UP;
            end
            od_en <= 6'(`MIO_RST_OD);
            misc <= `MIO_RST_MISC;
            trig_cfg <= 24'(`MIO_RST_TRIG);
            irq_enable <= '0;
        end else if (do_write) begin
            for (int p = 0; p < `MIO_NPORTS; p++) begin
                if (wr_in_ports && wr_port == p) begin
                    if (wr_kind == `MIO_OFS_CON) begin
                        con[p] <= merge(con[p], w_data_q, w_strb_q) & con_mask(p);
                    end
                    if (wr_kind == `MIO_OFS_DAT) begin
                        dat[p] <= merge(dat[p], w_data_q, w_strb_q) & width_mask(port_width(p));
                    end
                    if (wr_kind == `MIO_OFS_UP && p != 0) begin
                        up[p] <= merge(up[p], w_data_q, w_strb_q) & width_mask(port_width(p));
                    end
                end
            end
            if (aw_addr_q == `MIO_OFS_OD) begin
                od_en <= 6'(merge({26'h0, od_en}, w_data_q, w_strb_q));
            end
            if (aw_addr_q == `MIO_OFS_MISC) begin
                misc <= merge(misc, w_data_q, w_strb_q) & 32'h0000_007F;
            end
            if (aw_addr_q == `MIO_OFS_TRIG) begin
                trig_cfg <= 24'(merge({8'h00, trig_cfg}, w_data_q, w_strb_q));
            end
            if (aw_addr_q == `MIO_OFS_ENABLE) begin
                irq_enable <= 8'(merge({24'h0, irq_enable}, w_data_q, w_strb_q));
            end
        end
    end

    // Read path
    assign rd_port = araddr[6:4];
    assign rd_kind = araddr[3:2];
    assign rd_word = (araddr >= `MIO_OFS_PORT_END) ? 32'h0000_0000 :
        (rd_kind == `MIO_OFS_CON) ? con[rd_port] :
        (rd_kind == `MIO_OFS_DAT) ? port_slice(rd_pins, rd_port) :
        (rd_kind == `MIO_OFS_UP && rd_port != 3'h0) ? up[rd_port] : 32'h0000_0000;
    assign next_rdata = !addr_mapped(araddr) ? 32'h0000_0000 :
        (araddr < `MIO_OFS_PORT_END) ? rd_word :
        (araddr == `MIO_OFS_OD) ? {26'h0, od_en} :
        (araddr == `MIO_OFS_MISC) ? misc :
        (araddr == `MIO_OFS_TRIG) ? {8'h00, trig_cfg} :
        (araddr == `MIO_OFS_STATUS) ? {24'h0, irq_status} :
        (araddr == `MIO_OFS_ENABLE) ? {24'h0, irq_enable} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `MIO_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= addr_mapped(araddr) ? `MIO_RESP_OKAY : `MIO_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Pads are async: two flops first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= pad_in;
            sync2 <= sync1;
        end
    end
    assign port_pin_sync = sync2;

    // Misc control
    assign data_bus_pullup_en = ~{misc[`MIO_MISC_PU_HI], misc[`MIO_MISC_PU_LO]};
    assign usb_pad_ctrl = misc[`MIO_MISC_USB_LSB +: 2];
    assign clock_output_pin = clock_sources[misc[`MIO_MISC_CLK_LSB +: 2]];

    // Drive frozen on stop when hold chosen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_out <= '0;
            hold_oe <= '0;
        end else if (!stop_mode) begin
            hold_out <= live_out;
            hold_oe <= live_oe;
        end
    end

    // Pin map fixed by port bases
    genvar i;
    generate
        for (i = 0; i < `MIO_NPINS; i++) begin : g_pin
            localparam int P = pin_port(i);
            localparam int B = i - port_base(P);
            logic [1:0] fsel;
            logic f1_val;
            logic drv_val;
            logic drv_oe;
            if (P == 0) begin : g_a
                // No input path on port A
                assign fsel = con[0][B] ? mio_pkg::MIO_FSEL_FUNC1
                                        : mio_pkg::MIO_FSEL_OUTPUT;
                assign pad_pullup_en[i] = 1'b0;
            end else begin : g_io
                assign fsel = con[P][2*B +: 2];
                // Pull-up ignores fsel entirely
                assign pad_pullup_en[i] = ~up[P][B];
            end
            assign f1_val = (i == `MIO_CLOCK_OUTPUT_PIN_PIN) ? clock_output_pin : alt1_out[i];
            assign drv_val = (fsel == mio_pkg::MIO_FSEL_OUTPUT) ? dat[P][B] :
                             (fsel == mio_pkg::MIO_FSEL_FUNC1) ? f1_val :
                             (fsel == mio_pkg::MIO_FSEL_FUNC2) ? alt2_out[i] : 1'b0;
            assign drv_oe = (fsel == mio_pkg::MIO_FSEL_OUTPUT) ? 1'b1 :
                            (fsel == mio_pkg::MIO_FSEL_FUNC1) ? (P == 0 || alt1_oe[i]) :
                            (fsel == mio_pkg::MIO_FSEL_FUNC2) ? alt2_oe[i] : 1'b0;
            if (is_od_pin(i)) begin : g_od
                // Open drain only ever pulls low
                assign live_out[i] = od_en[od_index(i)] ? 1'b0 : drv_val;
                assign live_oe[i] = od_en[od_index(i)] ? (drv_oe && !drv_val) : drv_oe;
            end else begin : g_pp
                assign live_out[i] = drv_val;
                assign live_oe[i] = drv_oe;
            end
            assign pad_out[i] = (stop_mode && misc[`MIO_MISC_STOP_HOLD]) ? hold_out[i]
                                                                        : live_out[i];
            assign pad_oe[i] = !stop_mode ? live_oe[i] :
                               misc[`MIO_MISC_STOP_HOLD] ? hold_oe[i] : 1'b0;
            // Function pins read zero
            assign rd_pins[i] = (fsel == mio_pkg::MIO_FSEL_INPUT) ? sync2[i] :
                                (fsel == mio_pkg::MIO_FSEL_OUTPUT) ? dat[P][B] : 1'b0;
        end
    endgenerate

    // External interrupts on port E pins 0..7
    mio_irq_filter #(
        .N(`MIO_EXT_IRQ_INPUT_N)
    ) u_filter (
        .aclk(aclk),
        .aresetn(aresetn),
        .raw(sync2[`MIO_BASE_E +: `MIO_EXT_IRQ_INPUT_N]),
        .filtered(ext_irq_input_filt)
    );

    genvar k;
    generate
        for (k = 0; k < `MIO_EXT_IRQ_INPUT_N; k++) begin : g_ext_irq_input
            wire [2:0] cfg = trig_cfg[3*k +: 3];
            wire fall = ext_irq_input_prev[k] && !ext_irq_input_filt[k];
            wire rise = !ext_irq_input_prev[k] && ext_irq_input_filt[k];
            // Interrupt-function pins only
            assign ext_irq_input_mode[k] = con[4][2*k +: 2] == mio_pkg::MIO_FSEL_FUNC1;
            assign ext_irq_input_event[k] = ext_irq_input_mode[k] && (
                (cfg[2:1] == mio_pkg::MIO_TRIG_LEVEL) ? (ext_irq_input_filt[k] == cfg[0]) :
                (cfg[2:1] == mio_pkg::MIO_TRIG_FALL) ? fall :
                (cfg[2:1] == mio_pkg::MIO_TRIG_RISE) ? rise : (fall || rise));
        end
    endgenerate

    // Event beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_irq_input_prev <= '0;
            irq_status <= '0;
        end else begin
            ext_irq_input_prev <= ext_irq_input_filt;
            irq_status <= (irq_status & ~clear_word[`MIO_EXT_IRQ_INPUT_N-1:0]) | ext_irq_input_event;
        end
    end

    assign irq = |(irq_status & irq_enable);
endmodule

// ---- rtl/mio_cfg.svh ----
// Constants of the multiplexed pin block: pin map, register map, reset values.
// Assumes an 8-bit AXI4-Lite byte address and 32-bit data words.
//
// Contract
// - Ninety pins in seven ports of fixed widths
// - First port output only or memory function
// - Per-pin function select in every port
// - Pins take their default function after reset
// - Data register drives outputs, reads input pins
// - Pull-up disable bit: zero enables, one disables
// - Enabled pull-up works for every pin function
// - Six pads selectable open drain, one enables
// - Misc control: bus pull-ups, stop, USB, clock out
// - Eight external interrupts, five trigger kinds
// - Interrupt accepted only after four stable clocks
// - Data read of peripheral-function pin is undefined
// - First port select resets to all ones
`ifndef MIO_CFG_SVH
`define MIO_CFG_SVH

`define MIO_NPINS 90
`define MIO_NPORTS 7
`define MIO_BASE_A 0
`define MIO_BASE_B 18
`define MIO_BASE_C 34
`define MIO_BASE_D 50
`define MIO_BASE_E 61
`define MIO_BASE_F 73
`define MIO_BASE_G 80
`define MIO_WIDTH_A 18
`define MIO_WIDTH_B 16
`define MIO_WIDTH_C 16
`define MIO_WIDTH_D 11
`define MIO_WIDTH_E 12
`define MIO_WIDTH_F 7
`define MIO_WIDTH_G 10

`define MIO_CLOCK_OUTPUT_PIN_PIN 79
`define MIO_OD_PIN0 74
`define MIO_OD_PIN1 76
`define MIO_OD_PIN2 85
`define MIO_OD_PIN3 86
`define MIO_OD_PIN4 87
`define MIO_OD_PIN5 88
`define MIO_EXT_IRQ_INPUT_N 8

`define MIO_OFS_CON 2'h0
`define MIO_OFS_DAT 2'h1
`define MIO_OFS_UP 2'h2
`define MIO_OFS_PORT_END 8'h70
`define MIO_OFS_OD 8'h70
`define MIO_OFS_MISC 8'h74
`define MIO_OFS_TRIG 8'h78
`define MIO_OFS_STATUS 8'h7C
`define MIO_OFS_ENABLE 8'h80
`define MIO_OFS_CLEAR 8'h84

`define MIO_RST_CON_A 32'h0003_FFFF
`define MIO_RST_CON_B 32'hAAAA_AAAA
`define MIO_RST_CON 32'h0000_0000
`define MIO_RST_DAT 32'h0000_0000
`define MIO_RST_UP 32'h0000_0000
`define MIO_RST_MISC 32'h0000_0000
`define MIO_RST_OD 32'h0000_0000
`define MIO_RST_TRIG 32'h0000_0000

`define MIO_MISC_PU_LO 0
`define MIO_MISC_PU_HI 1
`define MIO_MISC_STOP_HOLD 2
`define MIO_MISC_USB_LSB 3
`define MIO_MISC_CLK_LSB 5

`define MIO_FILT_CYCLES 3'h3
`define MIO_RESP_OKAY 2'h0
`define MIO_RESP_SLVERR 2'h2

`endif

// ---- rtl/mio_pkg.sv ----
// Types shared by the multiplexed pin block.
// Assumes nothing beyond the constant header.
package mio_pkg;
    typedef enum logic [1:0] {
        MIO_FSEL_INPUT = 2'h0,
        MIO_FSEL_OUTPUT = 2'h1,
        MIO_FSEL_FUNC1 = 2'h2,
        MIO_FSEL_FUNC2 = 2'h3
    } mio_fsel_t;

    typedef enum logic [1:0] {
        MIO_TRIG_LEVEL = 2'h0,
        MIO_TRIG_FALL = 2'h1,
        MIO_TRIG_RISE = 2'h2,
        MIO_TRIG_BOTH = 2'h3
    } mio_trig_t;
endpackage

// ---- rtl/mio_irq_filter.sv ----
// Glitch filter for the external interrupt inputs.
// Assumes inputs already synchronised to aclk.
`timescale 1ns/1ps
`include "mio_cfg.svh"
module mio_irq_filter #(
    parameter int N = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] raw,
    output logic [N-1:0] filtered
);
    genvar k;
    generate
        for (k = 0; k < N; k++) begin : g_bit
            logic [2:0] cnt;
            // Take a new level after four differing edges
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cnt <= 3'h0;
                    filtered[k] <= 1'b0;
                end else if (raw[k] == filtered[k]) begin
                    cnt <= 3'h0;
                end else if (cnt == `MIO_FILT_CYCLES) begin
                    cnt <= 3'h0;
                    filtered[k] <= raw[k];
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    endgenerate
endmodule

// ---- testbench/mio_port_block_checker.sv ----
// Bus and pin checks for the pin block, bound to its top module.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`include "mio_cfg.svh"
module mio_port_block_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [`MIO_NPINS-1:0] pad_in,
    input wire logic [`MIO_NPINS-1:0] pad_oe,
    input wire logic [`MIO_NPINS-1:0] pad_pullup_en,
    input wire logic [`MIO_NPINS-1:0] port_pin_sync,
    input wire logic stop_mode,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_wr_resp; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("bvalid late");
    property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_b_block; bvalid |-> !awready && !wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write early");
    property p_rd_resp; arvalid && arready |=> rvalid; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("rvalid late");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("rdata moved");
    // Both stages out of reset first
    property p_sync2;
        $past(aresetn) && $past(aresetn, 2) |-> port_pin_sync == $past(pad_in, 2);
    endproperty
    a_sync2: assert property (p_sync2) else $error("sync depth");
    property p_a_drive; !stop_mode |-> &pad_oe[17:0]; endproperty
    a_a_drive: assert property (p_a_drive) else $error("port A undriven");
    property p_a_nopull; pad_pullup_en[17:0] == 18'h0_0000; endproperty
    a_a_nopull: assert property (p_a_nopull) else $error("port A pulled");
    property p_rst; $rose(aresetn) |-> !bvalid && !rvalid && !irq && &pad_pullup_en[89:18];
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_irq: cover property ($rose(irq));
endmodule

// ---- testbench/mio_pin_model.sv ----
// Board side of the pads: resolves own drive, board drive and pull-ups.
// Assumes the bench sets board drive; undriven unpulled pads wander.
`timescale 1ns/1ps
`include "mio_cfg.svh"
module mio_pin_model (
    input wire logic aclk,
    input wire logic [`MIO_NPINS-1:0] pad_out,
    input wire logic [`MIO_NPINS-1:0] pad_oe,
    input wire logic [`MIO_NPINS-1:0] pad_pullup_en,
    input wire logic [`MIO_NPINS-1:0] ext_drive,
    input wire logic [`MIO_NPINS-1:0] ext_level,
    output logic [`MIO_NPINS-1:0] pad_in
);
    // Floating pads toggle so stale levels cannot pass
    logic [`MIO_NPINS-1:0] wobble = '0;
    always @(posedge aclk) wobble <= ~wobble;
    always_comb begin
        for (int i = 0; i < `MIO_NPINS; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (ext_drive[i]) pad_in[i] = ext_level[i];
            else if (pad_pullup_en[i]) pad_in[i] = 1'h1;
            else pad_in[i] = wobble[i];
        end
    end
endmodule

// ---- testbench/mio_port_block_tb_top.sv ----
// Self-checking bench: register rows, then reset, pin and interrupt tests.
// Assumes the pin model stands in for the board; clock is 125 MHz.
`timescale 1ns/1ps
`include "mio_cfg.svh"
module mio_port_block_tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic u;} mio_row_t;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, stop_mode = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, q;
    logic [3:0] clock_sources = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, clock_output_pin;
    logic [1:0] bresp, rresp, r, er, data_bus_pullup_en, usb_pad_ctrl;
    logic [89:0] pad_in, pad_out, pad_oe, pad_pullup_en, port_pin_sync;
    logic [89:0] ext_drive = '0, ext_level = '0, alt1_out = {6{15'h5A3C}};
    logic [2:0] kinds [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    logic [4:0] idle = 5'h05;
    int bad_count = 0, checks = 0;
    mio_row_t rows [10] = '{
        '{8'h10, 32'h5555_5555, 32'h5555_5555, 1'h0}, '{8'h18, 32'hFFFF_FFFF, 32'h0000_FFFF, 1'h0},
        '{8'h30, 32'hFFFF_FFFF, 32'h003F_FFFF, 1'h0}, '{8'h60, 32'hFFFF_FFFF, 32'h000F_FFFF, 1'h0},
        '{8'h00, 32'hFFFF_FFFF, 32'h0003_FFFF, 1'h0}, '{8'h70, 32'hFFFF_FFFF, 32'h0000_003F, 1'h0},
        '{8'h74, 32'h0000_00FF, 32'h0000_007F, 1'h0}, '{8'h78, 32'hFFFF_FFFF, 32'h00FF_FFFF, 1'h0},
        '{8'h08, 32'h1234_5678, 32'h0000_0000, 1'h1}, '{8'hF0, 32'h1234_5678, 32'h0000_0000, 1'h1}};
    mio_port_block u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .pad_in, .pad_out, .pad_oe, .pad_pullup_en, .port_pin_sync, .alt1_out,
        .alt1_oe('0), .alt2_out('0), .alt2_oe('0), .stop_mode, .clock_sources,
        .clock_output_pin, .data_bus_pullup_en, .usb_pad_ctrl, .irq);
    mio_pin_model u_pins (.aclk, .pad_out, .pad_oe, .pad_pullup_en, .ext_drive, .ext_level,
        .pad_in);
    initial forever #4 aclk = ~aclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Channels released at own handshake
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        if (w) begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
        end else begin
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
        end
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (arready) arvalid <= 1'h0;
        end while (!(w ? bvalid : rvalid));
        q = rdata;
        r = w ? bresp : rresp;
        bready <= 1'h0;
        rready <= 1'h0;
        @(negedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        check(q, e);
    endtask
    task automatic pin(input logic v, input int n);
        @(posedge aclk);
        ext_level[61] <= v;
        repeat (n - 1) @(posedge aclk);
    endtask
    task automatic reset_dut;
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        finish_test();
    end
    initial begin
        reset_dut();
        foreach (rows[i]) begin
            er = rows[i].u ? `MIO_RESP_SLVERR : `MIO_RESP_OKAY;
            wr(rows[i].a, rows[i].d);
            check(r, er);
            rchk(rows[i].a, rows[i].e);
            check(r, er);
        end
        $display("test register rows done");
        // Mid-run reset restores start values
        reset_dut();
        rchk(8'h00, 32'h0003_FFFF);
        rchk(8'h10, 32'hAAAA_AAAA);
        rchk(8'h40, 32'h0000_0000);
        check(pad_out[17:0], alt1_out[17:0]);
        $display("test reset done");
        @(posedge aclk);
        ext_drive[49:34] <= 16'hFFFF;
        ext_level[49:34] <= 16'hA5A4;
        ext_drive[61] <= 1'h1;
        clock_sources <= 4'h4;
        wr(8'h20, 32'h0000_0021);
        wr(8'h24, 32'h0000_0001);
        check({pad_oe[34], pad_out[34]}, 2'h3);
        rchk(8'h24, 32'h0000_A5A1);
        check(pad_pullup_en[36:34], 3'h7);
        wr(8'h28, 32'h0000_0005);
        check(pad_pullup_en[36:34], 3'h2);
        $display("test data and pull-up done");
        wr(8'h50, 32'h0000_0004);
        wr(8'h54, 32'h0000_0002);
        check({pad_oe[74], pad_out[74]}, 2'h3);
        wr(8'h70, 32'h0000_0001);
        check({pad_oe[74], pad_out[74]}, 2'h0);
        wr(8'h54, 32'h0000_0000);
        check({pad_oe[74], pad_out[74]}, 2'h2);
        $display("test open drain done");
        wr(8'h74, 32'h0000_0059);
        check({clock_output_pin, usb_pad_ctrl, data_bus_pullup_en}, 5'h1E);
        @(posedge aclk);
        stop_mode <= 1'h1;
        @(negedge aclk);
        check(pad_oe[34], 1'h0);
        @(posedge aclk);
        stop_mode <= 1'h0;
        wr(8'h74, 32'h0000_005D);
        @(posedge aclk);
        stop_mode <= 1'h1;
        wr(8'h24, 32'h0000_0000);
        check({pad_oe[34], pad_out[34]}, 2'h3);
        @(posedge aclk);
        stop_mode <= 1'h0;
        $display("test misc and stop done");
        wr(8'h40, 32'h0000_AAAA);
        wr(8'h80, 32'h0000_0001);
        for (int k = 0; k < 5; k++) begin
            wr(8'h78, {29'h0, kinds[k]});
            pin(idle[k], 10);
            wr(8'h84, 32'h0000_00FF);
            check(irq, 1'h0);
            pin(~idle[k], 3);
            pin(idle[k], 10);
            check(irq, 1'h0);
            pin(~idle[k], 10);
            check(irq, 1'h1);
            rchk(8'h7C, 32'h0000_0001);
        end
        wr(8'h80, 32'h0000_0000);
        check(irq, 1'h0);
        $display("test interrupts done");
        finish_test();
    end
endmodule
bind mio_port_block mio_port_block_checker u_chk (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
    .pad_in, .pad_oe, .pad_pullup_en, .port_pin_sync, .stop_mode, .irq);
